// *** lce_line_cycle.sv ***
// Line cycle active energy accumulation and fundamental reactive power outputs.
// What this block does
// - Line cycle mode only while enable bit set
// - Transfer energies after programmed half cycles
// - Zero crossings counted per enabled phase
// - Half cycle target is unsigned sixteen bits
// - Zero crossing counter always runs
// - Count write while enabled restarts counter
// - Done flag set at period end
// - Masked done flag drives interrupt low
// - Writing one clears done flag
// - Same datapath and weight as continuous mode
// - Reactive power scaled to full scale word
// - Reactive values leave only via capture port
// - Voltage times ninety degree shifted current
// - Reactive output settles to 63% in about 512 ms at 8 kHz, not the documented 375 ms
// - Phase power gain scales reactive power
// - Per phase signed reactive offset removes offset
// - Offset words zero padded, sign extended
// - Threshold is eight bits then zeros
// - Pulses summed in 32-bit accumulators
module lce_line_cycle
    import lce_pkg::*;
#(
    parameter int NPH = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] line_cycle_mode_register,
    input wire logic [LCE_HALF_CYC_W-1:0] half_cycle_count,
    input wire logic half_cycle_count_wr,
    input wire logic [LCE_THR_W-1:0] active_energy_threshold,
    input wire logic [7:0] primary_interrupt_mask,
    input wire logic [7:0] primary_status_wr_data,
    input wire logic primary_status_wr,
    input wire logic [NPH-1:0] zero_cross,
    input wire logic acc_tick,
    input wire logic sample_tick,
    input wire logic [NPH*LCE_DSP_W-1:0] total_active_power,
    input wire logic [NPH*LCE_DSP_W-1:0] fund_active_power,
    input wire logic [NPH*24-1:0] fund_voltage,
    input wire logic [NPH*24-1:0] fund_current_shift90,
    input wire logic [NPH*LCE_GAIN_W-1:0] power_gain,
    input wire logic [NPH*32-1:0] fund_reactive_offset,
    input wire logic waveform_mode,
    output logic [7:0] primary_status_register,
    output logic primary_interrupt_n,
    output logic [NPH*LCE_ENERGY_W-1:0] total_active_energy_result,
    output logic [NPH*LCE_ENERGY_W-1:0] fund_active_energy_result,
    output logic [NPH*LCE_DSP_W-1:0] high_speed_capture_port,
    output logic high_speed_capture_valid
);

    // Mode register fields.
    logic lc_enable;
    logic [NPH-1:0] zx_select;
    assign lc_enable = line_cycle_mode_register[LCE_MODE_ENABLE_BIT];
    assign zx_select = line_cycle_mode_register[LCE_MODE_ZERO_CROSS_PHASE_SELECT_MSB:LCE_MODE_ZERO_CROSS_PHASE_SELECT_LSB];

    // Qualified zero crossings and their count in this cycle.
    logic [NPH-1:0] zx_qual;
    logic [1:0] zx_inc;
    assign zx_qual = zero_cross & zx_select;
    always_comb begin
        zx_inc = 2'h0;
        for (int k = 0; k < NPH; k++) begin
            zx_inc = zx_inc + {1'b0, zx_qual[k]};
        end
    end

    // Half cycle counter; unsigned seventeen-bit, free running in every mode.
    logic [LCE_HALF_CYC_W:0] zx_count_q;
    logic [LCE_HALF_CYC_W:0] zx_sum;
    logic period_end;
    logic restart;
    assign zx_sum = zx_count_q + {{(LCE_HALF_CYC_W - 1){1'b0}}, zx_inc};
    // The period closes when the target is reached or passed.
    assign period_end = (zx_sum >= {1'b0, half_cycle_count}) && (zx_inc != 2'h0);
    // A count write while enabled starts a fresh, accurate period.
    assign restart = half_cycle_count_wr && lc_enable;
    // Transfer happens only in line cycle mode.
    logic transfer;
    assign transfer = period_end && lc_enable && !restart;

    // Counter process: runs regardless of the mode bit.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            zx_count_q <= '0;
        end else if (restart || period_end) begin
            zx_count_q <= '0;
        end else begin
            zx_count_q <= zx_sum;
        end
    end

    // First stage threshold: eight-bit value followed by zeros.
    logic signed [LCE_THR_W+LCE_THR_ZEROS:0] thr;
    assign thr = {1'b0, active_energy_threshold, {LCE_THR_ZEROS{1'b0}}};

    // Energy datapath, one lane per phase and per kind (total, fundamental).
    genvar g;
    generate
        for (g = 0; g < 2 * NPH; g++) begin : g_lane
            localparam int PH = g % NPH;
            logic signed [LCE_DSP_W-1:0] pwr;
            logic signed [LCE_THR_W+LCE_THR_ZEROS:0] fs_sum;
            logic signed [LCE_THR_W+LCE_THR_ZEROS:0] fs_q;
            logic signed [LCE_THR_W+LCE_THR_ZEROS:0] fs_d;
            logic pos_pulse;
            logic neg_pulse;
            logic [LCE_ENERGY_W-1:0] acc_q;
            logic [LCE_ENERGY_W-1:0] acc_d;
            logic [LCE_ENERGY_W-1:0] res_q;
            // Pick the power word for this lane.
            assign pwr = (g < NPH) ? total_active_power[PH*LCE_DSP_W +: LCE_DSP_W]
                                   : fund_active_power[PH*LCE_DSP_W +: LCE_DSP_W];
            // First stage: add power, emit a pulse on reaching the threshold.
            assign fs_sum = fs_q + {{(LCE_THR_W + LCE_THR_ZEROS + 1 - LCE_DSP_W){pwr[LCE_DSP_W-1]}}, pwr};
            assign pos_pulse = acc_tick && (fs_sum >= thr);
            assign neg_pulse = acc_tick && (fs_sum <= -thr);
            assign fs_d = !acc_tick ? fs_q :
                          pos_pulse ? fs_sum - thr :
                          neg_pulse ? fs_sum + thr : fs_sum;
            // Second stage: 32-bit pulse accumulator, rolling over freely.
            assign acc_d = pos_pulse ? acc_q + 32'h1 :
                           neg_pulse ? acc_q - 32'h1 : acc_q;
            // First stage accumulator process.
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    fs_q <= '0;
                end else begin
                    fs_q <= fs_d;
                end
            end
            // Second stage process: restarts on a line cycle transfer or restart.
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    acc_q <= '0;
                end else if (restart) begin
                    acc_q <= '0;
                end else if (transfer) begin
                    // The pulse of this cycle opens the next period so none is lost.
                    acc_q <= acc_d - acc_q;
                end else begin
                    acc_q <= acc_d;
                end
            end
            // Result register: follows the accumulator outside line cycle mode.
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    res_q <= '0;
                end else if (transfer) begin
                    res_q <= acc_q;
                end else if (!lc_enable) begin
                    res_q <= acc_q;
                end
            end
            if (g < NPH) begin : g_tot
                assign total_active_energy_result[PH*LCE_ENERGY_W +: LCE_ENERGY_W] = res_q;
            end else begin : g_fund
                assign fund_active_energy_result[PH*LCE_ENERGY_W +: LCE_ENERGY_W] = res_q;
            end
        end
    endgenerate

    // Done flag: set at period end, cleared by writing one; set wins.
    logic done_q;
    logic done_clr;
    assign done_clr = primary_status_wr && primary_status_wr_data[LCE_STAT_DONE_BIT];
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else if (transfer) begin
            done_q <= 1'b1;
        end else if (done_clr) begin
            done_q <= 1'b0;
        end
    end
    // Status image and interrupt, both from the flag register.
    assign primary_status_register = {2'h0, done_q, 5'h00};
    assign primary_interrupt_n = !(done_q && primary_interrupt_mask[LCE_STAT_DONE_BIT]);

    // Fundamental reactive power lanes, one per phase.
    logic [NPH*LCE_DSP_W-1:0] var_word;
    generate
        for (g = 0; g < NPH; g++) begin : g_var
            logic signed [23:0] v;
            logic signed [23:0] i90;
            logic signed [47:0] vi;
            logic signed [49:0] scaled;
            logic signed [LCE_DSP_W-1:0] raw;
            logic signed [LCE_DSP_W-1:0] filt_q;
            logic signed [LCE_DSP_W-1:0] filt_step;
            logic signed [LCE_DSP_W+LCE_GAIN_W-1:0] gprod;
            logic signed [LCE_DSP_W-1:0] gained;
            logic signed [LCE_DSP_W-1:0] ofs28;
            assign v = fund_voltage[g*24 +: 24];
            assign i90 = fund_current_shift90[g*24 +: 24];
            // Voltage times current shifted by ninety degrees.
            assign vi = v * i90;
            // Full scale in-phase inputs give the full scale power word.
            assign scaled = (vi >>> 23) * $signed({1'b0, LCE_FULL_SCALE_POWER});
            assign raw = LCE_DSP_W'(scaled >>> 23);
            // First order low pass; its time constant sets the settling.
            assign filt_step = (raw - filt_q) >>> LCE_LPF_SHIFT;
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    filt_q <= '0;
                end else if (sample_tick) begin
                    filt_q <= filt_q + filt_step;
                end
            end
            // Gain: plus or minus one hundred percent over full code.
            assign gprod = filt_q * $signed(power_gain[g*LCE_GAIN_W +: LCE_GAIN_W]);
            assign gained = filt_q + LCE_DSP_W'(gprod >>> (LCE_GAIN_W - 1));
            // Offset word: low 24 bits used, upper eight padding bits ignored.
            assign ofs28 = {{(LCE_DSP_W - LCE_OFS_W){fund_reactive_offset[g*32+LCE_OFS_W-1]}},
                            fund_reactive_offset[g*32 +: LCE_OFS_W]};
            // Divide by sixteen, then remove the offset ahead of the capture port.
            assign var_word[g*LCE_DSP_W +: LCE_DSP_W] = (gained >>> LCE_VAR_DIV_SHIFT) + ofs28;
        end
    endgenerate

    // Capture port process: only path out for the reactive words.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            high_speed_capture_port <= '0;
            high_speed_capture_valid <= 1'b0;
        end else begin
            high_speed_capture_valid <= waveform_mode && sample_tick;
            if (waveform_mode && sample_tick) begin
                high_speed_capture_port <= var_word;
            end
        end
    end

    // Assertions guarding the control path.
    sequence s_period_close;
        transfer ##1 done_q;
    endsequence

    a_done_on_end: assert property (@(posedge mclk) disable iff (!rst_n)
        transfer |=> done_q) else $error("done flag not set at period end");
    a_done_needs_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(done_q) |-> $past(lc_enable)) else $error("done set outside line mode");
    a_clear_one: assert property (@(posedge mclk) disable iff (!rst_n)
        done_q && done_clr && !transfer |=> !done_q) else $error("done not cleared");
    a_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        transfer && done_clr |=> done_q) else $error("clear beat set");
    a_irq_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        s_period_close |-> (primary_interrupt_n
            == !primary_interrupt_mask[LCE_STAT_DONE_BIT])) else $error("irq wrong");
    a_count_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        restart |=> zx_count_q == '0) else $error("counter not restarted");
    a_count_free: assert property (@(posedge mclk) disable iff (!rst_n)
        !lc_enable && !period_end |=> zx_count_q == $past(zx_sum)) else $error("counter halted");
    a_zx_masked: assert property (@(posedge mclk) disable iff (!rst_n)
        zx_select == '0 && !restart |=> $stable(zx_count_q)) else $error("unselected zx counted");
    a_res_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        lc_enable && !transfer |=> $stable(total_active_energy_result)) else $error("early transfer");
    a_cap_only_wave: assert property (@(posedge mclk) disable iff (!rst_n)
        high_speed_capture_valid |-> $past(waveform_mode)) else $error("capture outside wave mode");

endmodule : lce_line_cycle

// *** lce_line_cycle_bench.sv ***
// Self-checking bench for the line cycle energy and fundamental reactive power block.
module lce_line_cycle_bench;
    import lce_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // One row of the zero-crossing table: phase select, pulse pattern, target, pulses, mask.
    typedef struct {
        logic [2:0] sel;
        logic [2:0] zc;
        logic [15:0] tgt;
        int n;
        logic msk;
    } lce_row_type;

    logic mclk;
    logic rst_n;
    logic [7:0] mode;
    logic [15:0] hcc;
    logic hcc_wr;
    logic [7:0] thr;
    logic [7:0] msk;
    logic [7:0] st_data;
    logic st_wr;
    logic [2:0] zc;
    logic acc_tick;
    logic sample_tick;
    logic [83:0] tot_p;
    logic [83:0] fund_p;
    logic [71:0] volt;
    logic [71:0] cur;
    logic [71:0] gain;
    logic [95:0] ofs;
    logic wave;
    logic [7:0] status;
    logic irq_n;
    logic [95:0] tot_e;
    logic [95:0] fund_e;
    logic [83:0] cap;
    logic cap_valid;
    int failures = 0;
    int tests_run = 0;
    lce_row_type rows [6];

    lce_line_cycle i_dut (.mclk(mclk), .rst_n(rst_n), .line_cycle_mode_register(mode),
        .half_cycle_count(hcc), .half_cycle_count_wr(hcc_wr), .active_energy_threshold(thr),
        .primary_interrupt_mask(msk), .primary_status_wr_data(st_data),
        .primary_status_wr(st_wr), .zero_cross(zc), .acc_tick(acc_tick),
        .sample_tick(sample_tick), .total_active_power(tot_p), .fund_active_power(fund_p),
        .fund_voltage(volt), .fund_current_shift90(cur), .power_gain(gain),
        .fund_reactive_offset(ofs), .waveform_mode(wave), .primary_status_register(status),
        .primary_interrupt_n(irq_n), .total_active_energy_result(tot_e),
        .fund_active_energy_result(fund_e), .high_speed_capture_port(cap),
        .high_speed_capture_valid(cap_valid));

    // The clock toggles every 25 ns, for a period of 50 ns.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Waits for the next rising edge, then moves a little past it to drive or sample.
    task automatic step();
        @(posedge mclk);
        #5;
    endtask

    // Compares one value, counts it, and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Raises a one-cycle pulse on the chosen zero-crossing inputs, then drops them all.
    task automatic pulse_zc(input logic [2:0] p);
        zc = p;
        step();
        zc = 3'b000;
    endtask

    // Writes the half cycle count; the strobe lasts exactly one cycle.
    task automatic write_count(input logic [15:0] v);
        hcc = v;
        hcc_wr = 1'b1;
        step();
        hcc_wr = 1'b0;
    endtask

    // Clears the done flag by writing a one to its status bit.
    task automatic clear_done();
        st_data = 8'h20;
        st_wr = 1'b1;
        step();
        st_wr = 1'b0;
        step();
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hang short well after the sequence should have ended.
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        final_report();
    end

    // Main sequence: reset, the table of zero-crossing cases, then the hand-written cases.
    initial begin
        rst_n = 1'b0; mode = 8'h00; hcc = 16'h0000; hcc_wr = 1'b0; thr = 8'h01;
        msk = 8'h00; st_data = 8'h00; st_wr = 1'b0; zc = 3'b000; acc_tick = 1'b0;
        sample_tick = 1'b0; tot_p = '0; fund_p = '0; volt = '0; cur = '0; gain = '0;
        ofs = '0; wave = 1'b0;
        // The band bit and nominal level are set by the host outside this block.
        rows = '{'{3'b001, 3'b001, 16'h0003, 3, 1'b1}, '{3'b010, 3'b011, 16'h0002, 2, 1'b0},
                 '{3'b111, 3'b111, 16'h0006, 2, 1'b1}, '{3'b101, 3'b111, 16'h0004, 2, 1'b1},
                 '{3'b100, 3'b100, 16'h0001, 1, 1'b0}, '{3'b110, 3'b111, 16'h0005, 3, 1'b1}};
        repeat (6) @(posedge mclk);
        #5;
        rst_n = 1'b1;
        step();
        chk(status, 32'h0);
        chk(irq_n, 32'h1);
        chk(tot_e[31:0], 32'h0);
        chk(cap_valid, 32'h0);
        // Each row counts pulses from the selected phases up to the target.
        foreach (rows[r]) begin
            mode = {2'b00, rows[r].sel, 3'b001};
            msk = {2'b00, rows[r].msk, 5'b00000};
            write_count(rows[r].tgt);
            for (int k = 0; k < rows[r].n - 1; k++) begin
                pulse_zc(rows[r].zc);
                step();
            end
            chk(status[5], 32'h0);
            pulse_zc(rows[r].zc);
            chk(status[5], 32'h1);
            chk(irq_n, {31'h0, ~rows[r].msk});
            clear_done();
            chk({status[5], irq_n}, 32'h1);
        end
        // A count write in mid-period restarts the counter.
        mode = 8'h09;
        write_count(16'h0003);
        pulse_zc(3'b001);
        pulse_zc(3'b001);
        write_count(16'h0003);
        pulse_zc(3'b001);
        pulse_zc(3'b001);
        chk(status[5], 32'h0);
        pulse_zc(3'b001);
        chk(status[5], 32'h1);
        clear_done();
        // With the mode off the counter runs and no flag is set; results follow the accumulators.
        mode = 8'h08;
        repeat (4) pulse_zc(3'b001);
        step();
        chk(status[5], 32'h0);
        // Energy over one period: two ticks make one first-stage pulse in each phase 0 lane.
        mode = 8'h09;
        write_count(16'h0001);
        tot_p[27:0] = 28'h4000000;
        fund_p[27:0] = 28'hc000000;
        repeat (8) begin
            acc_tick = 1'b1;
            step();
            acc_tick = 1'b0;
            step();
        end
        tot_p = '0;
        fund_p = '0;
        repeat (3) step();
        pulse_zc(3'b001);
        chk(tot_e[31:0], 32'h4);
        chk(fund_e[31:0], 32'hfffffffc);
        chk(tot_e[63:32], 32'h0);
        clear_done();
        // Capture port carries the sign-extended offsets when waveform mode is on.
        ofs[31:0] = 32'h00800000;
        ofs[63:32] = 32'h00000123;
        wave = 1'b1;
        sample_tick = 1'b1;
        step();
        sample_tick = 1'b0;
        chk(cap_valid, 32'h1);
        chk(cap[27:0], 32'h0f800000);
        chk(cap[55:28], 32'h00000123);
        step();
        chk(cap_valid, 32'h0);
        wave = 1'b0;
        sample_tick = 1'b1;
        step();
        sample_tick = 1'b0;
        chk(cap_valid, 32'h0);
        final_report();
    end
endmodule // lce_line_cycle_bench

// *** lce_pkg.sv ***
// Constants shared by the line cycle energy and fundamental reactive power block.
package lce_pkg;
    // Line cycle mode register field positions.
    localparam int LCE_MODE_ENABLE_BIT = 0;
    localparam int LCE_MODE_ZERO_CROSS_PHASE_SELECT_LSB = 3;
    localparam int LCE_MODE_ZERO_CROSS_PHASE_SELECT_MSB = 5;
    localparam int LCE_MODE_CLR_READ_BIT = 6;
    // Primary status and mask bit of the line cycle done flag.
    localparam int LCE_STAT_DONE_BIT = 5;
    // Computation mode bit that names the network frequency band.
    localparam int LCE_COMP_FREQ_BIT = 14;
    // Register widths.
    localparam int LCE_HALF_CYC_W = 16;
    localparam int LCE_GAIN_W = 24;
    localparam int LCE_OFS_W = 24;
    localparam int LCE_DSP_W = 28;
    localparam int LCE_THR_W = 8;
    localparam int LCE_THR_ZEROS = 27;
    localparam int LCE_ENERGY_W = 32;
    // Power word at full scale for in-phase inputs, and the divide by sixteen.
    localparam logic [24:0] LCE_FULL_SCALE_POWER = 25'h19ce5de;
    localparam int LCE_VAR_DIV_SHIFT = 4;
    // Reset values.
    localparam logic [LCE_HALF_CYC_W-1:0] LCE_HALF_CYC_RST = 16'hffff;
    // Settling of the fundamental reactive power, in milliseconds, at 8 kHz samples.
    localparam int LCE_SETTLE_63_MS = 375;
    localparam int LCE_SETTLE_FULL_MS = 875;
    localparam int LCE_SAMPLE_HZ = 8000;
    localparam int LCE_LPF_SHIFT = $clog2(LCE_SETTLE_63_MS * LCE_SAMPLE_HZ / 1000);
    localparam int LCE_SETTLE_FULL_SAMPLES = LCE_SETTLE_FULL_MS * LCE_SAMPLE_HZ / 1000;
    // Clock rate of the block.
    localparam int LCE_CLK_HZ = 20000000;
endpackage : lce_pkg
